/* rtl/dscg_pkg.sv */
// dscg_pkg: register map, field layout and types of the power-state clock gating block
package dscg_pkg;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_RUN = 12'h100;
  localparam logic [11:0] OFS_SLEEP = 12'h110;
  localparam logic [11:0] OFS_DEEP = 12'h120;
  localparam logic [11:0] OFS_CFG = 12'h130;
  localparam logic [11:0] OFS_INT_STAT = 12'h140;
  localparam logic [11:0] OFS_INT_MASK = 12'h144;
  localparam logic [11:0] OFS_STATE = 12'h148;

  // gating register field positions
  localparam int unsigned PWM_BIT = 20;
  localparam int unsigned ADC_BIT = 16;
  localparam int unsigned RATE_MSB = 11;
  localparam int unsigned RATE_LSB = 8;
  localparam int unsigned HIB_BIT = 6;
  localparam int unsigned WDT_BIT = 3;
  localparam logic [31:0] WMASK = 32'h0011_0F48;

  // reset values
  localparam logic [31:0] RST_RUN = 32'h0000_0000;
  localparam logic [31:0] RST_SLEEP = 32'h0000_0000;
  localparam logic [31:0] RST_DEEP = 32'h0000_0040;
  localparam logic RST_ACG = 1'b0;

  // converter sample rate codes
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;
  localparam logic [3:0] RATE_500K = 4'h2;
  localparam logic [3:0] RATE_MAX = RATE_500K;

  // configuration, status and interrupt layout
  localparam int unsigned CFG_ACG_BIT = 0;
  localparam int unsigned STATE_PS_LSB = 4;
  localparam int unsigned NUM_UNITS = 4;
  localparam int unsigned UNIT_WDT = 0;
  localparam int unsigned UNIT_HIB = 1;
  localparam int unsigned UNIT_ADC = 2;
  localparam int unsigned UNIT_PWM = 3;
  localparam logic [3:0] FAULT_CAPABLE = 4'b1101;
  localparam int unsigned INT_W = 5;
  localparam int unsigned INT_STATE_BIT = 4;

  // power state of the system
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_SLEEP = 2'b01,
    PS_DEEP = 2'b10
  } dscg_pstate_t;

  // one gating word in field form
  typedef struct packed {
    logic pwm;
    logic adc;
    logic [3:0] rate;
    logic powerdown_unit_clock_enable;
    logic wdt;
  } dscg_gate_t;

  // pull the live fields out of a gating word
  function automatic dscg_gate_t dscg_unpack(input logic [31:0] w);
    dscg_gate_t g;
    g.pwm = w[PWM_BIT];
    g.adc = w[ADC_BIT];
    g.rate = w[RATE_MSB:RATE_LSB];
    g.powerdown_unit_clock_enable = w[HIB_BIT];
    g.wdt = w[WDT_BIT];
    return g;
  endfunction : dscg_unpack

endpackage : dscg_pkg

/* rtl/dscg_gate_reg.sv */
// dscg_gate_reg: one gating register with reserved-bit masking and rate capping
`timescale 1ns/1ps
module dscg_gate_reg #(
  parameter logic [31:0] RST_VAL = dscg_pkg::RST_RUN,
  parameter logic [3:0] RATE_MAX = dscg_pkg::RATE_MAX
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  // stored word
  output logic [31:0] q
);

  logic [31:0] gate_ff;
  logic [31:0] nxt_gate;
  logic [3:0] wr_rate;

  // reserved bits never stored; rate above the limit is pulled down to it
  always_comb begin
    wr_rate = wdata[dscg_pkg::RATE_MSB:dscg_pkg::RATE_LSB];
    nxt_gate = wdata & dscg_pkg::WMASK;
    if (wr_rate > RATE_MAX) begin
      nxt_gate[dscg_pkg::RATE_MSB:dscg_pkg::RATE_LSB] = RATE_MAX;
    end
  end

  // storage; reset value is per instance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_ff <= RST_VAL;
    end else if (wr_en) begin
      gate_ff <= nxt_gate;
    end
  end

  assign q = gate_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_GATE_RESV_ZERO: assert property ((q & ~dscg_pkg::WMASK) == 32'h0000_0000)
    else $error("reserved gating bit set");
  AST_GATE_RATE_CAP: assert property (q[dscg_pkg::RATE_MSB:dscg_pkg::RATE_LSB] <= RATE_MAX)
    else $error("sample rate above limit");
  AST_GATE_HOLD: assert property (!wr_en |=> q == $past(q))
    else $error("gating word changed without write");

endmodule : dscg_gate_reg

/* rtl/dscg_fault_chk.sv */
// dscg_fault_chk: bus fault detection for accesses to unclocked units
`timescale 1ns/1ps
module dscg_fault_chk #(
  parameter int unsigned N = dscg_pkg::NUM_UNITS,
  parameter logic [3:0] CAPABLE = dscg_pkg::FAULT_CAPABLE
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // unit accesses and applied enables
  input wire logic [N-1:0] access,
  input wire logic [N-1:0] clk_en,
  // fault answer
  output logic fault,
  output logic [N-1:0] fault_unit
);

  logic [N-1:0] nxt_unit;
  logic [N-1:0] unit_ff;
  logic fault_ff;

  // a unit faults only if gated off and it can fault at all
  for (genvar u = 0; u < N; u++) begin : g_unit
    assign nxt_unit[u] = access[u] && !clk_en[u] && CAPABLE[u];
  end

  // one-cycle fault pulse, replacing the normal completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_ff <= '0;
      fault_ff <= 1'b0;
    end else begin
      unit_ff <= nxt_unit;
      fault_ff <= |nxt_unit;
    end
  end

  assign fault = fault_ff;
  assign fault_unit = unit_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_FAULT_GATED: assert property (|(access & ~clk_en & CAPABLE[N-1:0]) |=> fault)
    else $error("gated access without fault");
  AST_FAULT_CLOCKED: assert property ((access & ~clk_en) == '0 |=> !fault)
    else $error("fault on clocked access");
  AST_HIB_NOFAULT: assert property (!fault_unit[dscg_pkg::UNIT_HIB])
    else $error("powerdown unit faulted");

endmodule : dscg_fault_chk

/* rtl/dscg_clock_gate.sv */
// dscg_clock_gate: run, sleep and deep-sleep unit clock gating with fault and interrupt logic
//
// Notes on behaviour
// - each gating bit enables one unit clock; zero stops and disables it.
// - access to a gated-off unit other than the powerdown unit answers with a bus fault.
// - gating bits reset to zero unless another reset value is given.
// - three same-layout registers: run, sleep and deep-sleep.
// - sleep and deep-sleep registers act only with auto gating selected.
// - deep-sleep register sits at 0x120, resets to 0x00000040.
// - bit 20 enables the pulse-width modulator clock; clear means faults.
// - bit 16 enables converter unit 0 clock; clear means faults.
// - bit 6 enables the powerdown unit clock; no fault for it.
// - bit 3 enables the watchdog clock; clear means faults.
// - bits 11:8 pick sample rate: 2=500K, 1=250K, 0=125K.
// - stored sample rate never exceeds the converter maximum.
// - reserved bits read zero and ignore writes.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module dscg_clock_gate #(
  parameter logic [3:0] RATE_MAX = dscg_pkg::RATE_MAX
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // system power state
  input wire logic [1:0] power_state,
  // unit side
  input wire logic [3:0] unit_access,
  output logic [3:0] unit_clk_en,
  output logic [3:0] converter_sample_rate,
  output logic bus_fault,
  output logic [3:0] fault_unit,
  // interrupt
  output logic irq
);

  localparam int unsigned NREG = 3;
  localparam logic [11:0] REG_OFS [NREG] = '{dscg_pkg::OFS_RUN, dscg_pkg::OFS_SLEEP, dscg_pkg::OFS_DEEP};
  localparam logic [31:0] REG_RST [NREG] = '{dscg_pkg::RST_RUN, dscg_pkg::RST_SLEEP, dscg_pkg::RST_DEEP};

  logic [31:0] gate_q [NREG];
  dscg_pkg::dscg_gate_t run_g;
  dscg_pkg::dscg_gate_t sleep_g;
  dscg_pkg::dscg_gate_t deep_g;
  dscg_pkg::dscg_gate_t sel_g;
  dscg_pkg::dscg_pstate_t ps_ff;
  dscg_pkg::dscg_pstate_t nxt_ps;
  logic acg_ff;
  logic [3:0] clk_en_ff;
  logic [3:0] nxt_clk_en;
  logic [3:0] rate_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [dscg_pkg::INT_W-1:0] int_stat_ff;
  logic [dscg_pkg::INT_W-1:0] int_mask_ff;
  logic [dscg_pkg::INT_W-1:0] nxt_int_stat;
  logic [dscg_pkg::INT_W-1:0] nxt_int_mask;
  logic [dscg_pkg::INT_W-1:0] set_vec;
  logic [dscg_pkg::INT_W-1:0] clr_vec;
  logic irq_ff;
  logic state_evt;
  logic fault_pulse;
  logic [3:0] fault_vec;

  // the three gating registers share one layout and one write decode
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    dscg_gate_reg #(
      .RST_VAL(REG_RST[r]),
      .RATE_MAX(RATE_MAX)
    ) u_gate (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(reg_wr && (reg_addr == REG_OFS[r])),
      .wdata(reg_wdata),
      .q(gate_q[r])
    );
  end

  // field views of the stored words
  assign run_g = dscg_pkg::dscg_unpack(gate_q[0]);
  assign sleep_g = dscg_pkg::dscg_unpack(gate_q[1]);
  assign deep_g = dscg_pkg::dscg_unpack(gate_q[2]);

  // auto gating select lives in the run clock config register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acg_ff <= dscg_pkg::RST_ACG;
    end else if (reg_wr && reg_addr == dscg_pkg::OFS_CFG) begin
      acg_ff <= reg_wdata[dscg_pkg::CFG_ACG_BIT];
    end
  end

  // unknown power state codes fall back to run, the safe choice
  always_comb begin
    case (power_state)
      2'b01: nxt_ps = dscg_pkg::PS_SLEEP;
      2'b10: nxt_ps = dscg_pkg::PS_DEEP;
      default: nxt_ps = dscg_pkg::PS_RUN;
    endcase
  end

  // power state sampled once so the selection never glitches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_ff <= dscg_pkg::PS_RUN;
    end else begin
      ps_ff <= nxt_ps;
    end
  end

  // register choice; without auto gating the run word rules all states
  always_comb begin
    if (!acg_ff) begin
      sel_g = run_g;
    end else begin
      case (ps_ff)
        dscg_pkg::PS_SLEEP: sel_g = sleep_g;
        dscg_pkg::PS_DEEP: sel_g = deep_g;
        default: sel_g = run_g;
      endcase
    end
  end

  // one enable per unit, indexed as the fault checker expects
  always_comb begin
    nxt_clk_en = '0;
    nxt_clk_en[dscg_pkg::UNIT_PWM] = sel_g.pwm;
    nxt_clk_en[dscg_pkg::UNIT_ADC] = sel_g.adc;
    nxt_clk_en[dscg_pkg::UNIT_HIB] = sel_g.powerdown_unit_clock_enable;
    nxt_clk_en[dscg_pkg::UNIT_WDT] = sel_g.wdt;
  end

  // applied enables and rate, registered so the gates see clean levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_ff <= '0;
      rate_ff <= dscg_pkg::RATE_125K;
    end else begin
      clk_en_ff <= nxt_clk_en;
      rate_ff <= sel_g.rate;
    end
  end

  // fault decision uses the enables the units actually see
  dscg_fault_chk #(
    .N(dscg_pkg::NUM_UNITS),
    .CAPABLE(dscg_pkg::FAULT_CAPABLE)
  ) u_fault (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .access(unit_access),
    .clk_en(clk_en_ff),
    .fault(fault_pulse),
    .fault_unit(fault_vec)
  );

  // a power state move that changes the register in use is an event
  assign state_evt = acg_ff && (nxt_ps != ps_ff);

  // sticky status: a fresh event beats a same-cycle write-one-to-clear
  always_comb begin
    set_vec = '0;
    set_vec[3:0] = fault_vec;
    set_vec[dscg_pkg::INT_STATE_BIT] = state_evt;
    clr_vec = '0;
    if (reg_wr && reg_addr == dscg_pkg::OFS_INT_STAT) begin
      clr_vec = reg_wdata[dscg_pkg::INT_W-1:0];
    end
    nxt_int_stat = (int_stat_ff & ~clr_vec) | set_vec;
    nxt_int_mask = int_mask_ff;
    if (reg_wr && reg_addr == dscg_pkg::OFS_INT_MASK) begin
      nxt_int_mask = reg_wdata[dscg_pkg::INT_W-1:0];
    end
  end

  // status, mask and irq; irq is computed from next values to stay in step
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_ff <= '0;
      int_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      int_mask_ff <= nxt_int_mask;
      irq_ff <= |(nxt_int_stat & nxt_int_mask);
    end
  end

  // read decode; unmapped addresses and idle cycles read zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        dscg_pkg::OFS_RUN: nxt_rdata = gate_q[0];
        dscg_pkg::OFS_SLEEP: nxt_rdata = gate_q[1];
        dscg_pkg::OFS_DEEP: nxt_rdata = gate_q[2];
        dscg_pkg::OFS_CFG: nxt_rdata[dscg_pkg::CFG_ACG_BIT] = acg_ff;
        dscg_pkg::OFS_INT_STAT: nxt_rdata[dscg_pkg::INT_W-1:0] = int_stat_ff;
        dscg_pkg::OFS_INT_MASK: nxt_rdata[dscg_pkg::INT_W-1:0] = int_mask_ff;
        dscg_pkg::OFS_STATE: begin
          nxt_rdata[3:0] = clk_en_ff;
          nxt_rdata[dscg_pkg::STATE_PS_LSB+1:dscg_pkg::STATE_PS_LSB] = ps_ff;
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs, all straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign unit_clk_en = clk_en_ff;
  assign converter_sample_rate = rate_ff;
  assign bus_fault = fault_pulse;
  assign fault_unit = fault_vec;
  assign irq = irq_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // deep-sleep word selected for two cycles running
  sequence s_deep_held;
    acg_ff && ps_ff == dscg_pkg::PS_DEEP ##1 acg_ff && ps_ff == dscg_pkg::PS_DEEP;
  endsequence

  // write to the deep word followed by its read, back to back or after one idle cycle
  sequence s_deep_wr_rd;
    reg_wr && reg_addr == dscg_pkg::OFS_DEEP ##[1:2] reg_rd && reg_addr == dscg_pkg::OFS_DEEP;
  endsequence

  AST_RUN_ONLY: assert property (!acg_ff |=> unit_clk_en[dscg_pkg::UNIT_PWM] == $past(run_g.pwm))
    else $error("sleep word used without auto gating");
  AST_DEEP_APPLIED: assert property (s_deep_held |=> unit_clk_en[dscg_pkg::UNIT_WDT] == $past(deep_g.wdt))
    else $error("deep word not applied");
  AST_DEEP_READBACK: assert property (s_deep_wr_rd |=> (reg_rdata & ~dscg_pkg::WMASK) == 32'h0000_0000)
    else $error("reserved bits read back");
  AST_SET_WINS: assert property (|set_vec |=> (int_stat_ff & $past(set_vec)) == $past(set_vec))
    else $error("event lost against clear");
  AST_IRQ_LEVEL: assert property (irq == |(int_stat_ff & int_mask_ff))
    else $error("irq disagrees with status");
  AST_RDATA_ONE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : dscg_clock_gate

/* verif/dscg_sw_model.sv */
// dscg_sw_model: processor-side register bus master for the clock gating block
`timescale 1ns/1ps
module dscg_sw_model (
  // clock
  ref_clk,
  // register port
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata
);
  input wire logic ref_clk;
  output logic [11:0] reg_addr;
  output logic [31:0] reg_wdata;
  output logic reg_wr;
  output logic reg_rd;
  input wire logic [31:0] reg_rdata;

  // bus idles with both strobes low from time zero
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write strobe; an idle edge follows so strobes never merge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // read-modify-write keeps whatever the reserved bits returned
  task automatic rmw(input logic [11:0] a, input logic [31:0] set, input logic [31:0] clr);
    logic [31:0] v;
    rd(a, v);
    wr(a, (v & ~clr) | set);
  endtask : rmw
endmodule : dscg_sw_model

/* verif/tb_top.sv */
// tb_top: self-checking bench for the power-state clock gating block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0] power_state = 2'b00;
  logic [3:0] unit_access = 4'h0;
  logic [3:0] unit_clk_en;
  logic [3:0] converter_sample_rate;
  logic bus_fault;
  logic [3:0] fault_unit;
  logic irq;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] rd_q[$];
  logic [3:0] flt_q[$];
  logic rd_seen = 1'b0;
  logic acc_seen = 1'b0;
  logic [31:0] w;
  logic [31:0] d;
  logic [3:0] i;

  always #2 ref_clk = ~ref_clk;

  dscg_sw_model dscg_sw_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  dscg_clock_gate dscg_clock_gate_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_state(power_state), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
    .converter_sample_rate(converter_sample_rate), .bus_fault(bus_fault), .fault_unit(fault_unit),
    .irq(irq));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // stored form of a written word: reserved bits dropped, rate capped at the maximum
  function automatic logic [31:0] exp_word(input logic [31:0] x);
    logic [31:0] m;
    m = x & dscg_pkg::WMASK;
    if (m[11:8] > dscg_pkg::RATE_MAX) m[11:8] = dscg_pkg::RATE_MAX;
    return m;
  endfunction : exp_word

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd_q.push_back(e);
    dscg_sw_model_inst.rd(a, x);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  // answers stand one cycle only, so each is paired with the oldest note at the next edge
  always @(posedge ref_clk) begin
    if (rd_seen) chk("reg_rdata", reg_rdata, rd_q.pop_front());
    if (acc_seen) begin
      chk("fault_unit", 32'(fault_unit), 32'(flt_q[0]));
      chk("bus_fault", 32'(bus_fault), 32'(flt_q.pop_front() != 4'h0));
    end
    rd_seen <= reg_rd;
    acc_seen <= |unit_access;
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #80000;
    mismatches++;
    final_report();
  end

  initial begin
    w = $urandom(32'hc3f1);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values and an unmapped address
    rd_chk(dscg_pkg::OFS_RUN, 32'h0000_0000);
    rd_chk(dscg_pkg::OFS_SLEEP, 32'h0000_0000);
    rd_chk(dscg_pkg::OFS_DEEP, 32'h0000_0040);
    rd_chk(12'h124, 32'h0000_0000);
    chk("unit_clk_en", 32'(unit_clk_en), 32'h0000_0000);
    // random words through the deep-sleep register, reserved bits and rate cap
    repeat (8) begin
      w = $urandom;
      dscg_sw_model_inst.wr(dscg_pkg::OFS_DEEP, w);
      rd_chk(dscg_pkg::OFS_DEEP, exp_word(w));
    end
    // every rate code and enable pattern through the run word, auto gating off
    for (int j = 0; j < 16; j++) begin
      i = 4'(j);
      w = {11'h000, i[0], 3'h0, i[1], 4'h0, i, 1'b0, i[2], 2'b00, i[3], 3'h0};
      dscg_sw_model_inst.wr(dscg_pkg::OFS_RUN, w | ($urandom & ~dscg_pkg::WMASK));
      settle(2);
      chk("unit_clk_en", 32'(unit_clk_en), 32'({i[0], i[1], i[2], i[3]}));
      chk("sample_rate", 32'(converter_sample_rate), (exp_word(w) >> 8) & 32'h0000_000f);
    end
    // back-to-back accesses to gated-off units; the powerdown unit never faults
    dscg_sw_model_inst.wr(dscg_pkg::OFS_RUN, 32'h0000_0000);
    settle(2);
    for (int u = 0; u < 4; u++) begin
      @(posedge ref_clk);
      unit_access <= 4'(1 << u);
      flt_q.push_back(u == 1 ? 4'h0 : 4'(1 << u));
    end
    @(posedge ref_clk);
    unit_access <= 4'h0;
    dscg_sw_model_inst.wr(dscg_pkg::OFS_RUN, 32'h0011_0048);
    settle(2);
    @(posedge ref_clk);
    unit_access <= 4'hf;
    flt_q.push_back(4'h0);
    @(posedge ref_clk);
    unit_access <= 4'h0;
    // interrupt: raise, mask, unmask, clear
    dscg_sw_model_inst.wr(dscg_pkg::OFS_INT_STAT, 32'h0000_001f);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_INT_MASK, 32'h0000_0001);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_RUN, 32'h0000_0000);
    settle(3);
    chk("irq", 32'(irq), 32'h0000_0000);
    @(posedge ref_clk);
    unit_access <= 4'h1;
    flt_q.push_back(4'h1);
    @(posedge ref_clk);
    unit_access <= 4'h0;
    settle(3);
    chk("irq", 32'(irq), 32'h0000_0001);
    rd_chk(dscg_pkg::OFS_INT_STAT, 32'h0000_0001);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_INT_MASK, 32'h0000_0000);
    settle(2);
    chk("irq", 32'(irq), 32'h0000_0000);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_INT_MASK, 32'h0000_0001);
    settle(2);
    chk("irq", 32'(irq), 32'h0000_0001);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_INT_STAT, 32'h0000_0001);
    settle(2);
    chk("irq", 32'(irq), 32'h0000_0000);
    // three words, one per power state; only auto gating lets sleep and deep words act
    dscg_sw_model_inst.wr(dscg_pkg::OFS_RUN, 32'h0000_0008);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_SLEEP, 32'h0001_0000);
    dscg_sw_model_inst.wr(dscg_pkg::OFS_DEEP, 32'h0010_0000);
    rd_chk(dscg_pkg::OFS_SLEEP, 32'h0001_0000);
    for (int a = 0; a < 2; a++) begin
      dscg_sw_model_inst.wr(dscg_pkg::OFS_CFG, 32'(a));
      for (int p = 0; p < 3; p++) begin
        @(posedge ref_clk);
        power_state <= 2'(p);
        settle(3);
        chk("unit_clk_en", 32'(unit_clk_en), (a == 0 || p == 0) ? 32'h1 : (p == 1 ? 32'h4 : 32'h8));
      end
    end
    @(posedge ref_clk);
    power_state <= 2'b00;
    // power-state moves under auto gating leave the event bit set, faults were cleared
    rd_chk(dscg_pkg::OFS_INT_STAT, 32'h0000_0010);
    rd_q.push_back(32'h0000_0008);
    dscg_sw_model_inst.rmw(dscg_pkg::OFS_RUN, 32'h0000_0040, 32'h0000_0000);
    rd_chk(dscg_pkg::OFS_RUN, 32'h0000_0048);
    settle(3);
    final_report();
  end
endmodule : tb_top
